/* File: pkg/dds_pkg.sv */
// dds_pkg: constants and carrier types of the nco sine core
// assumes one clock (pclk), an apb master, asynchronous select pins
// Behaviour
// - 32-bit phase accumulator spans one output cycle, wraps on overflow
// - every clock the fifo has room adds the selected 32-bit step, modulo two to the 32
// - output frequency is word times clock frequency over two to the 32
// - frequency select low takes word 0, high takes word 1
// - switching words changes only the step, accumulator phase continues
// - selected 12-bit offset is added to the accumulator top bits
// - four phase offset words, each one 4096th of a cycle per step
// - top 12 bits of the modulated phase address the sine table
// - table maps 12-bit phase to 10-bit amplitude code
// - two phase select pins form the offset index, bit0 is low bit
// - select pins sampled on rising clock; other party holds them steady
// - reset clears accumulator to zero, stored words stay untouched
// - select or word change reaches the amplitude after six clocks
package dds_pkg;
  localparam int ACC_W = 32;
  localparam int PH_W = 12;
  localparam int AMP_W = 10;
  localparam int APB_AW = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int LAT_CYC = 6;
  localparam real CLK_MHZ = 250.0;
  // register byte offsets
  localparam logic [APB_AW-1:0] OFS_FREQ_WORD_0 = 8'h00;
  localparam logic [APB_AW-1:0] OFS_FREQ_WORD_1 = 8'h04;
  localparam logic [APB_AW-1:0] OFS_PH0 = 8'h08;
  localparam logic [APB_AW-1:0] OFS_ACC = 8'h18;
  localparam logic [APB_AW-1:0] OFS_STAT = 8'h1C;
  // word indices, byte offset over four
  localparam logic [2:0] IDX_FREQ_WORD_1 = 3'h1;
  localparam logic [2:0] IDX_PH0 = 3'h2;
  localparam logic [2:0] IDX_PH3 = 3'h5;
  localparam logic [2:0] IDX_ACC = 3'h6;
  localparam logic [2:0] IDX_STAT = 3'h7;
  localparam logic [AMP_W-1:0] AMP_MID = 10'h200;
  typedef struct packed {
    logic fsel;
    logic [1:0] psel;
  } dds_sel_t;
  typedef struct packed {
    logic vld;
    logic [2:0] idx;
    logic [31:0] data;
  } dds_wr_t;
endpackage

/* File: design/dds_fifo.sv */
// dds_fifo: small first-word-fall-through fifo with valid/ready both sides
// assumes producer and consumer on the same clock
`timescale 1ns/100ps
module dds_fifo #(
  parameter int W = 10,
  parameter int D = 4
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic in_valid, // producer offers a word
  output logic in_ready, // room for a word
  input wire logic [W-1:0] in_data, // word in
  output logic out_valid, // head word present
  input wire logic out_ready, // consumer takes head
  output logic [W-1:0] out_data, // head word
  output logic [$clog2(D):0] level // words held
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic push_w, pop_w;

  // pointers wrap freely, so depth must be a power of two
  if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
    $error("fifo depth must be a power of two");
  end

  assign in_ready = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign push_w = in_valid && in_ready;
  assign pop_w = out_valid && out_ready;
  assign out_data = mem_q[rp_q];
  assign level = cnt_q;

  // storage needs no reset, count guards it
  always_ff @(posedge pclk) begin
    if (push_w) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_q + AW'(push_w);
      rp_q <= rp_q + AW'(pop_w);
      cnt_q <= cnt_q + (AW+1)'(push_w) - (AW+1)'(pop_w);
    end
  end
endmodule // dds_fifo

/* File: design/dds_sine_rom.sv */
// dds_sine_rom: registered sine lookup, offset binary amplitude
// assumes table contents fixed at elaboration
`timescale 1ns/100ps
module dds_sine_rom #(
  parameter int AW = 12,
  parameter int DW = 10
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic en, // advance the stage
  input wire logic [AW-1:0] addr, // phase address
  output logic [DW-1:0] amp // amplitude code
);
  localparam int N = 1 << AW;
  localparam int HALF = 1 << (DW - 1);
  localparam real TWO_PI = 6.283185307179586;

  // two extra phase bits keep table error below converter lsb
  if (AW != DW + 2) begin : g_chk
    $error("phase address must be two bits wider than amplitude");
  end

  // offset binary: positive half tops at 2*HALF-1, negative bottoms at 0
  function automatic int sine_code(int i);
    real s;
    s = $sin(TWO_PI * i / N);
    if (s >= 0.0) sine_code = HALF + $rtoi(s * (HALF - 1) + 0.5);
    else sine_code = HALF - $rtoi(-s * HALF + 0.5);
  endfunction

  logic [DW-1:0] table_w [N];
  for (genvar g = 0; g < N; g++) begin : g_tab
    localparam logic [DW-1:0] CODE = DW'(sine_code(g));
    assign table_w[g] = CODE;
  end

  // lookup stage, reset shows midscale
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      amp <= DW'(HALF);
    end else if (en) begin
      amp <= table_w[addr];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  rom_mid_a: assert property (en && addr == '0 |=> amp == DW'(HALF))
    else $error("zero phase is not midscale");
  rom_peak_a: assert property (en && addr == AW'(N / 4) |=> amp == DW'(2 * HALF - 1))
    else $error("quarter phase is not full scale");
  rom_trough_a: assert property (en && addr == AW'(3 * N / 4) |=> amp == '0)
    else $error("three quarter phase is not zero");
endmodule // dds_sine_rom

/* File: design/dds_nco.sv */
// dds_nco: phase accumulator, phase modulator, sine lookup, output fifo
// assumes apb master on pclk; select pins asynchronous; converter
// takes codes through a valid/ready pair and is normally always ready
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/100ps
module dds_nco
  import dds_pkg::*;
#(
  parameter int FIFO_D = FIFO_DEPTH
) (
  input wire logic pclk, // master clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high writes
  input wire logic [APB_AW-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic freq_word_select, // frequency word pick
  input wire logic phase_sel_bit0, // offset index low bit
  input wire logic phase_sel_bit1, // offset index high bit
  output logic [AMP_W-1:0] dac_code, // amplitude to converter
  output logic dac_valid, // code present
  input wire logic dac_ready // converter takes code
);

  // pin synchronisers, first stage read only by the second
  dds_sel_t sel_s1_q;
  dds_sel_t sel_s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_s1_q <= '0;
      sel_s2_q <= '0;
    end else begin
      sel_s1_q.fsel <= freq_word_select;
      sel_s1_q.psel <= {phase_sel_bit1, phase_sel_bit0};
      sel_s2_q <= sel_s1_q;
    end
  end

  // apb decode
  logic setup_w;
  logic access_w;
  logic mapped_w;
  logic [2:0] idx_w;
  assign setup_w = psel && !penable;
  assign access_w = psel && penable;
  assign idx_w = paddr[4:2];
  assign mapped_w = (paddr[APB_AW-1:5] == '0) && (paddr[1:0] == 2'b00);
  // zero-wait slave: every access completes in one access cycle
  assign pready = 1'b1;
  assign pslverr = access_w && !mapped_w;

  // phase word slot of a register index, shared by the write and read paths
  function automatic logic [1:0] poff_slot(logic [2:0] idx);
    poff_slot = 2'(idx - IDX_PH0);
  endfunction

  // below two words the fifo cannot hold a code while the next is looked up
  if (FIFO_D < 2) begin : g_chk
    $error("fifo depth below two");
  end

  // write pipe: two stages, so a word lands one edge later than a pin sampled on the same edge
  dds_wr_t wr0_q;
  dds_wr_t wr1_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr0_q <= '0;
      wr1_q <= '0;
    end else begin
      wr0_q.vld <= access_w && pwrite && mapped_w && (idx_w <= IDX_PH3);
      wr0_q.idx <= idx_w;
      wr0_q.data <= pwdata;
      wr1_q <= wr0_q;
    end
  end

  // stored words carry no reset: the accumulator reset must not touch them
  logic [ACC_W-1:0] freq_q [2];
  logic [PH_W-1:0] poff_q [4];
  // frequency words, one write port
  always_ff @(posedge pclk) begin
    if (wr1_q.vld && wr1_q.idx <= IDX_FREQ_WORD_1) begin
      freq_q[wr1_q.idx[0]] <= wr1_q.data;
    end
  end

  // phase words keep the low twelve bits; upper write bits are dropped
  always_ff @(posedge pclk) begin
    if (wr1_q.vld && wr1_q.idx >= IDX_PH0) begin
      poff_q[poff_slot(wr1_q.idx)] <= wr1_q.data[PH_W-1:0];
    end
  end

  // stall: the accumulator, offset, address and lookup stages hold while the fifo is full
  logic adv_w;
  logic run_q;
  logic [AMP_W-1:0] amp_w;
  logic [$clog2(FIFO_D):0] level_w;

  // selected step; index 1 only when the select is high
  logic [ACC_W-1:0] step_w;
  assign step_w = freq_q[sel_s2_q.fsel];

  // accumulator: only the step changes on a switch, never the phase
  logic [ACC_W-1:0] acc_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
    end else if (adv_w) begin
      acc_q <= ACC_W'(acc_q + step_w);
    end
  end

  // offset pick, aligned with the accumulator stage
  logic [PH_W-1:0] poff_sel_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poff_sel_q <= '0;
    end else if (adv_w) begin
      poff_sel_q <= poff_q[sel_s2_q.psel];
    end
  end

  // phase modulation after accumulation, low bits dropped
  logic [PH_W-1:0] addr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= '0;
    end else if (adv_w) begin
      addr_q <= PH_W'(acc_q[ACC_W-1 -: PH_W] + poff_sel_q);
    end
  end

  // valid into the fifo once out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
    end else begin
      run_q <= 1'b1;
    end
  end

  dds_sine_rom #(
    .AW(PH_W),
    .DW(AMP_W)
  ) u_rom (
    .pclk(pclk),
    .presetn(presetn),
    .en(adv_w),
    .addr(addr_q),
    .amp(amp_w)
  );

  // fifo between lookup and converter; its ready stalls the whole pipe
  dds_fifo #(
    .W(AMP_W),
    .D(FIFO_D)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(run_q),
    .in_ready(adv_w),
    .in_data(amp_w),
    .out_valid(dac_valid),
    .out_ready(dac_ready),
    .out_data(dac_code),
    .level(level_w)
  );

  // read data registered in the setup cycle
  logic [31:0] rd_w;
  always_comb begin
    rd_w = '0;
    case (idx_w)
      IDX_ACC: rd_w = acc_q;
      IDX_STAT: rd_w = {24'h0, 1'(level_w), sel_s2_q, run_q, 3'h0};
      default: begin
        if (idx_w <= IDX_FREQ_WORD_1) begin
          rd_w = freq_q[idx_w[0]];
        end else begin
          rd_w = {20'h0, poff_q[poff_slot(idx_w)]}; // upper bits read zero
        end
      end
    endcase
  end

  logic [31:0] rdata_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
    end else if (setup_w) begin
      rdata_q <= mapped_w ? rd_w : '0;
    end
  end
  assign prdata = rdata_q;

  // helper: cycles since reset, so checks skip pre-reset history
  logic [2:0] age_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q <= '0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence wr_freq_word_0_s;
    access_w && pwrite && paddr == OFS_FREQ_WORD_0;
  endsequence

  sequence wr_ph0_s;
    access_w && pwrite && paddr == OFS_PH0;
  endsequence

  // case equality: words not yet written after power-up must not trip these
  acc_step_a: assert property (adv_w |=> acc_q === ACC_W'($past(acc_q) + $past(step_w)))
    else $error("accumulator did not add the step");

  acc_hold_a: assert property (!adv_w |=> $stable(acc_q))
    else $error("accumulator moved during stall");

  sel_sync_a: assert property (age_q == 3'h7 |->
      sel_s2_q == $past({freq_word_select, phase_sel_bit1, phase_sel_bit0}, 2))
    else $error("select pins not two stages behind");

  fsel_pick_a: assert property (adv_w |=>
      ACC_W'(acc_q - $past(acc_q)) === ($past(sel_s2_q.fsel) ? $past(freq_q[1]) : $past(freq_q[0])))
    else $error("wrong frequency word used");

  cont_a: assert property ($changed(sel_s2_q.fsel) && adv_w |=>
      acc_q === ACC_W'($past(acc_q) + $past(step_w)))
    else $error("phase jumped on frequency switch");

  psel_pick_a: assert property (adv_w |=> poff_sel_q === $past(poff_q[sel_s2_q.psel]))
    else $error("wrong phase offset used");

  addr_mod_a: assert property (adv_w |=>
      addr_q === PH_W'($past(acc_q[ACC_W-1 -: PH_W]) + $past(poff_sel_q)))
    else $error("lookup address not top bits plus offset");

  // stored on the second edge after the access, so seen on the third
  wr_lat_a: assert property (wr_freq_word_0_s |-> ##3 freq_q[0] == $past(pwdata, 3))
    else $error("frequency word not stored two clocks after write");

  ph_lat_a: assert property (wr_ph0_s |-> ##3 poff_q[0] == $past(pwdata[PH_W-1:0], 3))
    else $error("phase word not stored two clocks after write");

  rst_acc_a: assert property ($rose(age_q == 3'h1) |-> acc_q === ACC_W'($past(step_w)))
    else $error("accumulator not zero out of reset");

  err_map_a: assert property (access_w && !mapped_w |-> pslverr && pready)
    else $error("unmapped access not flagged");

  // read path: data captured in the setup cycle stands through the access
  sequence rd_acc_s;
    setup_w && paddr == OFS_ACC;
  endsequence

  sequence rd_stat_s;
    setup_w && paddr == OFS_STAT;
  endsequence

  rd_acc_a: assert property (rd_acc_s |=> prdata == $past(acc_q))
    else $error("accumulator read does not match");

  rd_stat_a: assert property (rd_stat_s |=> prdata[6:4] == $past(sel_s2_q) && prdata[3] == $past(run_q))
    else $error("status read does not show synced selects");

  rd_ph_a: assert property (setup_w && mapped_w && idx_w >= IDX_PH0 && idx_w <= IDX_PH3 |=>
      prdata[31:PH_W] == '0)
    else $error("phase word upper bits not zero");

  rd_unmap_a: assert property (setup_w && !mapped_w |=> prdata == '0)
    else $error("unmapped read returned data");

  // read-only words never enter the write pipe
  ro_ignore_a: assert property (access_w && pwrite && idx_w >= IDX_ACC |=> !wr0_q.vld)
    else $error("write to read-only word accepted");

  // write pipe: a word is seen on the third edge after its access edge
  sequence wr_freq_word_1_s;
    access_w && pwrite && paddr == OFS_FREQ_WORD_1;
  endsequence

  wr1_lat_a: assert property (wr_freq_word_1_s |-> ##3 freq_q[1] == $past(pwdata, 3))
    else $error("second frequency word not stored");

  ph3_lat_a: assert property (access_w && pwrite && mapped_w && idx_w == IDX_PH3 |->
      ##3 poff_q[3] == $past(pwdata[PH_W-1:0], 3))
    else $error("fourth phase word not stored");

  // stall: the accumulator, offset, address and lookup stages hold while the fifo is full, so no code is lost
  pipe_hold_a: assert property (!adv_w |=> $stable(poff_sel_q) && $stable(addr_q) && $stable(amp_w))
    else $error("pipe stage moved during stall");

  dac_hold_a: assert property (dac_valid && !dac_ready |=> dac_valid && $stable(dac_code))
    else $error("offered code changed before it was taken");

  // a carry out of the top bit reads back as a smaller phase
  acc_wrap_a: assert property (adv_w && ({1'b0, acc_q} + {1'b0, step_w}) > {1'b0, {ACC_W{1'b1}}} |=>
      acc_q < $past(acc_q))
    else $error("accumulator did not wrap");

  // the synced offset index reaches the lookup address two stage edges later
  sequence flow2_s;
    adv_w ##1 adv_w;
  endsequence

  sel_flow_a: assert property (flow2_s |=>
      addr_q === PH_W'($past(acc_q[ACC_W-1 -: PH_W]) + $past(poff_q[sel_s2_q.psel], 2)))
    else $error("offset did not reach the address in two stages");

  // out of reset the first code offered is midscale
  mid_push_a: assert property ($rose(age_q == 3'h2) |-> dac_valid && dac_code == AMP_MID)
    else $error("first code after reset not midscale");

endmodule // dds_nco

/* File: testbench/dds_dac_model.sv */
// dds_dac_model: converter side of the nco, takes one code per cycle
// assumes codes arrive through a valid/ready pair on pclk
`timescale 1ns/100ps
module dds_dac_model
  import dds_pkg::*;
(
  input wire logic pclk, // master clock
  input wire logic presetn, // async reset, active low
  input wire logic [AMP_W-1:0] dac_code, // code offered
  input wire logic dac_valid, // code present
  output logic dac_ready, // converter takes code
  input wire logic stall, // bench asks for back-pressure
  output logic [AMP_W-1:0] last_code, // most recent code taken
  output int taken // codes taken so far
);
  // ready follows stall one edge late, like a real sink
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_ready <= 1'b0;
      taken <= 0;
      last_code <= '0;
    end else begin
      dac_ready <= !stall;
      if (dac_valid && dac_ready) begin
        taken <= taken + 1;
        last_code <= dac_code;
      end
    end
  end
endmodule // dds_dac_model

/* File: testbench/dds_nco_sine_lut_tb.sv */
// dds_nco_sine_lut_tb: apb access, offset select, latency, step and stall tests
// assumes dds_nco at 250 MHz with the converter model as its sink
`timescale 1ns/100ps
module dds_nco_sine_lut_tb;
  import dds_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, fsel, pb0, pb1, stall, dac_valid, dac_ready, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, a1, a2;
  logic [AMP_W-1:0] dac_code;
  logic e;
  int miscompares = 0;
  int num_checks = 0;
  int taken, t1;
  logic [9:0] exp_code [4] = '{10'h200, 10'h3FF, 10'h000, 10'h3FF};
  logic [11:0] ofs [4] = '{12'h000, 12'h400, 12'hC00, 12'h400};
  dds_nco dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .freq_word_select(fsel), .phase_sel_bit0(pb0), .phase_sel_bit1(pb1),
    .dac_code(dac_code), .dac_valid(dac_valid), .dac_ready(dac_ready));
  dds_dac_model dac (.pclk(pclk), .presetn(presetn), .dac_code(dac_code), .dac_valid(dac_valid),
    .dac_ready(dac_ready), .stall(stall), .last_code(), .taken(taken));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_code(input logic [9:0] exp);
    num_checks++;
    if (dac_code !== exp) begin
      miscompares++;
      $display("ERROR t=%0t code got %h exp %h", $time, dac_code, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      final_report();
    end else begin
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // let a write still in the internal pipe land before reset clears it
  task automatic do_reset();
    repeat (4) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1 chk({31'h0, dac_valid}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // two reads three cycles apart of the accumulator
  task automatic step_check(input logic [31:0] exp);
    apb(1'b0, OFS_ACC, 32'h0);
    a1 = r;
    apb(1'b0, OFS_ACC, 32'h0);
    a2 = r;
    chk(a2 - a1, exp);
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, fsel, pb0, pb1, stall} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, OFS_FREQ_WORD_0, 32'h0);
    apb(1'b1, OFS_FREQ_WORD_1, 32'h0);
    for (int i = 0; i < 4; i++) apb(1'b1, OFS_PH0 + 8'(4 * i), {20'hFFFFF, ofs[i]});
    do_reset();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, OFS_PH0 + 8'(4 * i), 32'h0);
      chk(r, {20'h0, ofs[i]});
    end
    apb(1'b1, OFS_ACC, 32'h1234);
    apb(1'b0, OFS_ACC, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 8'h02, 32'h5);
    chk({31'h0, e}, 32'h1);
    repeat (8) @(posedge pclk);
    #1 chk_code(exp_code[0]);
    // each index change shows on the sixth edge, not before
    for (int i = 1; i < 4; i++) begin
      @(posedge pclk);
      pb0 <= i[0];
      pb1 <= i[1];
      repeat (5) @(posedge pclk);
      #1 chk_code(exp_code[i - 1]);
      @(posedge pclk);
      #1 chk_code(exp_code[i]);
    end
    // status: level low bit, select 0, index 3, running
    apb(1'b0, OFS_STAT, 32'h0);
    chk(r, 32'h000000B8);
    apb(1'b1, OFS_FREQ_WORD_0, 32'h60000000);
    apb(1'b1, OFS_FREQ_WORD_1, 32'h00000010);
    repeat (4) @(posedge pclk);
    step_check(32'h20000000);
    @(posedge pclk);
    fsel <= 1'b1;
    repeat (8) @(posedge pclk);
    step_check(32'h30);
    // converter stalls: fifo fills, then the whole pipe halts
    @(posedge pclk);
    stall <= 1'b1;
    repeat (12) @(posedge pclk);
    step_check(32'h0);
    chk({31'h0, dac_valid}, 32'h1);
    t1 = taken;
    repeat (4) @(posedge pclk);
    chk(32'(taken - t1), 32'h0);
    @(posedge pclk);
    stall <= 1'b0;
    repeat (12) @(posedge pclk);
    step_check(32'h30);
    final_report();
  end
endmodule // dds_nco_sine_lut_tb
